// ---- src/rcv_top.sv ----
// Regulator control register with VBUS status, interrupt and reset level
`timescale 1ns/100ps
`default_nettype none
`include "rcv_params.svh"
module rcv_top (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rstn,
	// Special-function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	output logic            sfr_sel,
	// VBUS pin
	input  wire logic       vbus_pin,
	// System controls
	input  wire logic       vbus_irq_enable,
	input  wire logic       usb_reset_source_sel,
	output logic            vbus_irq,
	output logic            vbus_sys_reset,
	// Regulator analog controls
	output logic            regulator_off,
	output logic            regulator_low_power_sel
);
	// ==========================================
	// State
	rcv_pkg::rcv_state_t state_ff;
	rcv_pkg::rcv_state_t nxt_state;
	logic                vbus_level_status;
	logic                vbus_match;
	logic                ctrl_write;
	logic                ctrl_read;

	function automatic logic hit(input logic [7:0] a);
		hit = (a == `RCV_REG_CTRL_ADDR);
	endfunction

	// ==========================================
	// VBUS synchronisation
	rcv_sync u_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.async_in (vbus_pin),
		.sync_out (vbus_level_status)
	);

	// Polarity zero matches low VBUS
	assign vbus_match = (vbus_level_status == state_ff.ctrl.vbus_irq_polarity);

	// Strobes that reach the control register
	assign ctrl_write = sfr_wr && hit(sfr_addr);
	assign ctrl_read = sfr_rd && hit(sfr_addr);

	// ==========================================
	// Register update
	always_comb begin
		nxt_state = state_ff;
		if (ctrl_write) begin
			// Bit 6 and low nibble are not stored
			nxt_state.ctrl.regulator_off = sfr_wdata[`RCV_BIT_OFF];
			nxt_state.ctrl.vbus_irq_polarity = sfr_wdata[`RCV_BIT_POL];
			nxt_state.ctrl.regulator_low_power_sel = sfr_wdata[`RCV_BIT_LP];
		end
		nxt_state.rdata = 8'h00;
		if (ctrl_read) begin
			nxt_state.rdata[`RCV_BIT_OFF] = state_ff.ctrl.regulator_off;
			nxt_state.rdata[`RCV_BIT_VBUS] = vbus_level_status;
			nxt_state.rdata[`RCV_BIT_POL] = state_ff.ctrl.vbus_irq_polarity;
			nxt_state.rdata[`RCV_BIT_LP] = state_ff.ctrl.regulator_low_power_sel;
			// Low nibble stays zero
			nxt_state.rdata = nxt_state.rdata & ~`RCV_RSVD_MASK;
		end
		if (!rstn) begin
			nxt_state.ctrl = rcv_pkg::rcv_ctrl_t'(3'h0);
			nxt_state.rdata = `RCV_REG_CTRL_RESET;
		end
	end

	always_ff @(posedge core_clk) begin
		state_ff <= nxt_state;
	end

	// ==========================================
	// Outputs
	assign sfr_rdata = state_ff.rdata;
	assign sfr_sel = hit(sfr_addr);
	assign regulator_off = state_ff.ctrl.regulator_off;
	assign regulator_low_power_sel = state_ff.ctrl.regulator_low_power_sel;
	// No pending flag: level follows the match directly
	assign vbus_irq = rstn && vbus_irq_enable && vbus_match;
	assign vbus_sys_reset = rstn && usb_reset_source_sel && vbus_match;

	// ==========================================
	// Checks: register writes
	AST_OFF_WRITE: assert property (
		@(posedge core_clk) disable iff (!rstn)
		ctrl_write |=> regulator_off == $past(sfr_wdata[`RCV_BIT_OFF]))
		else $error("regulator_off did not follow write");
	AST_LP_WRITE: assert property (
		@(posedge core_clk) disable iff (!rstn)
		ctrl_write |=> regulator_low_power_sel == $past(sfr_wdata[`RCV_BIT_LP]))
		else $error("low power select did not follow write");
	AST_POL_WRITE: assert property (
		@(posedge core_clk) disable iff (!rstn)
		ctrl_write |=> state_ff.ctrl.vbus_irq_polarity == $past(sfr_wdata[`RCV_BIT_POL]))
		else $error("polarity did not follow write");
	// Stored control bits must not glitch between writes
	AST_OFF_HOLD: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!ctrl_write |=> $stable(regulator_off))
		else $error("regulator_off changed without write");
	AST_LP_HOLD: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!ctrl_write |=> $stable(regulator_low_power_sel))
		else $error("low power select changed without write");
	AST_POL_HOLD: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!ctrl_write |=> $stable(state_ff.ctrl.vbus_irq_polarity))
		else $error("polarity changed without write");

	// ==========================================
	// Checks: read path
	AST_VBUS_READ: assert property (
		@(posedge core_clk) disable iff (!rstn)
		ctrl_read |=> sfr_rdata[`RCV_BIT_VBUS] == $past(vbus_level_status))
		else $error("status bit wrong");
	AST_READ_OFF: assert property (
		@(posedge core_clk) disable iff (!rstn)
		ctrl_read |=> sfr_rdata[`RCV_BIT_OFF] == $past(regulator_off))
		else $error("off bit read wrong");
	AST_READ_POL: assert property (
		@(posedge core_clk) disable iff (!rstn)
		ctrl_read |=> sfr_rdata[`RCV_BIT_POL] == $past(state_ff.ctrl.vbus_irq_polarity))
		else $error("polarity bit read wrong");
	AST_READ_LP: assert property (
		@(posedge core_clk) disable iff (!rstn)
		ctrl_read |=> sfr_rdata[`RCV_BIT_LP] == $past(regulator_low_power_sel))
		else $error("low power bit read wrong");
	AST_RSVD_ZERO: assert property (
		@(posedge core_clk) disable iff (!rstn)
		sfr_rdata[3:0] == 4'h0)
		else $error("reserved bits not zero");
	// Shared read bus: only the addressed cycle may drive data
	AST_READ_OTHER: assert property (
		@(posedge core_clk) disable iff (!rstn)
		sfr_rd && !sfr_sel |=> sfr_rdata == 8'h00)
		else $error("other address read not zero");
	AST_RDATA_IDLE: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!sfr_rd |=> sfr_rdata == 8'h00)
		else $error("read data not cleared");

	// ==========================================
	// Checks: VBUS path
	AST_VBUS_SYNC: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$rose(vbus_pin) ##1 vbus_pin[*2] |-> vbus_level_status)
		else $error("vbus not seen two cycles later");
	// Sync flops are cleared in reset, so two clean cycles first
	AST_SYNC_DELAY: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) && $past(rstn, 2) |-> vbus_level_status == $past(vbus_pin, 2))
		else $error("vbus status latency wrong");

	// ==========================================
	// Checks: interrupt level
	AST_IRQ_LEVEL: assert property (
		@(posedge core_clk) disable iff (!rstn)
		vbus_irq == (vbus_irq_enable
			&& (vbus_level_status == state_ff.ctrl.vbus_irq_polarity)))
		else $error("irq not a level of the match");
	AST_IRQ_POL_LOW: assert property (
		@(posedge core_clk) disable iff (!rstn)
		vbus_irq_enable && !state_ff.ctrl.vbus_irq_polarity && !vbus_level_status |-> vbus_irq)
		else $error("low polarity irq missing");
	AST_IRQ_POL_HIGH: assert property (
		@(posedge core_clk) disable iff (!rstn)
		vbus_irq_enable && state_ff.ctrl.vbus_irq_polarity && vbus_level_status |-> vbus_irq)
		else $error("high polarity irq missing");
	AST_IRQ_OFF: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!vbus_irq_enable |-> !vbus_irq)
		else $error("irq while disabled");
	// No pending flag: a mismatch must drop the request at once
	AST_IRQ_NO_LATCH: assert property (
		@(posedge core_clk) disable iff (!rstn)
		vbus_level_status != state_ff.ctrl.vbus_irq_polarity |-> !vbus_irq)
		else $error("irq held after mismatch");

	// ==========================================
	// Checks: system reset level
	AST_RST_LEVEL: assert property (
		@(posedge core_clk) disable iff (!rstn)
		vbus_sys_reset |-> usb_reset_source_sel && vbus_match)
		else $error("spurious system reset");
	AST_RST_ACTIVE: assert property (
		@(posedge core_clk) disable iff (!rstn)
		usb_reset_source_sel && vbus_level_status == state_ff.ctrl.vbus_irq_polarity
		|-> vbus_sys_reset)
		else $error("system reset missing");
	AST_RST_UNSEL: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!usb_reset_source_sel |-> !vbus_sys_reset)
		else $error("system reset while not selected");

	// ==========================================
	// Checks: block reset
	AST_RESET_QUIET: assert property (
		@(posedge core_clk)
		!rstn |-> !vbus_irq && !vbus_sys_reset)
		else $error("irq or system reset during block reset");
	AST_RESET_CLEAR: assert property (
		@(posedge core_clk)
		!rstn |=> !regulator_off && !regulator_low_power_sel && sfr_rdata == 8'h00)
		else $error("outputs not cleared by reset");

	// ==========================================
	// Coverage
	COV_IRQ: cover property (@(posedge core_clk) disable iff (!rstn) $rose(vbus_irq));
	COV_RST: cover property (@(posedge core_clk) disable iff (!rstn) $rose(vbus_sys_reset));
	COV_OFF: cover property (@(posedge core_clk) disable iff (!rstn) $rose(regulator_off));
	COV_LP: cover property (@(posedge core_clk) disable iff (!rstn) $rose(regulator_low_power_sel));
	COV_READ: cover property (@(posedge core_clk) disable iff (!rstn)
		ctrl_read ##1 sfr_rdata[`RCV_BIT_VBUS]);
endmodule // rcv_top
`default_nettype wire

// ---- src/rcv_params.svh ----
// Constants for the regulator control and VBUS detect block
//
// Contract
// - A one in bit 7 shuts the regulator off and a zero keeps it running.
// - Bit 6 reads the synchronised VBUS level (one present, zero absent) and ignores writes.
// - Bit 5 picks the VBUS level that raises the interrupt, zero for low and one for high.
// - When enabled the VBUS interrupt is a pure level while VBUS matches polarity, with no latch.
// - When USB is a reset source, a system reset is asserted while VBUS matches polarity.
// - Bit 4 puts the regulator in low-power suspend mode when one, normal mode when zero.
// - Bits 3 to 0 read as zero and software writes zeros there.
`ifndef RCV_PARAMS_SVH
`define RCV_PARAMS_SVH

// ==========================================
// Register map
`define RCV_REG_CTRL_ADDR  8'hc9
`define RCV_REG_CTRL_RESET 8'h00

// ==========================================
// Field positions
`define RCV_BIT_OFF    7
`define RCV_BIT_VBUS   6
`define RCV_BIT_POL    5
`define RCV_BIT_LP     4
`define RCV_RSVD_MASK  8'h0f

`endif

// ---- src/rcv_pkg.sv ----
// Types for the regulator control and VBUS detect block
package rcv_pkg;
	typedef struct packed {
		logic regulator_off;
		logic vbus_irq_polarity;
		logic regulator_low_power_sel;
	} rcv_ctrl_t;

	typedef struct packed {
		rcv_ctrl_t  ctrl;
		logic [7:0] rdata;
	} rcv_state_t;

	typedef struct packed {
		logic [1:0] sync;
	} rcv_sync_state_t;
endpackage

// ---- src/rcv_sync.sv ----
// Two-flop synchroniser for the VBUS pin
`timescale 1ns/100ps
`default_nettype none
module rcv_sync (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rstn,
	// Pin in, synchronised out
	input  wire logic async_in,
	output logic      sync_out
);
	rcv_pkg::rcv_sync_state_t state_ff;
	rcv_pkg::rcv_sync_state_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		// First stage feeds only the second
		nxt_state.sync = {state_ff.sync[0], async_in};
		if (!rstn) begin
			nxt_state.sync = 2'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		state_ff <= nxt_state;
	end

	assign sync_out = state_ff.sync[1];
endmodule // rcv_sync
`default_nettype wire

// ---- verification/rcv_vbus_host.sv ----
// Host side of the VBUS line
`timescale 1ns/100ps
`default_nettype none
module rcv_vbus_host (
	// Wanted level and host lag
	input  wire logic       want_on,
	input  wire logic [7:0] lag_ns,
	// Supply line
	output logic            vbus_pin
);
	// Driven supply, never floats
	initial vbus_pin = 1'b0;
	always @(want_on) vbus_pin <= #(lag_ns) want_on;
endmodule // rcv_vbus_host
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the regulator control block
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic       core_clk, rstn, wr, rd, en, src, want, rd_q, old, sel, pin, irq, srst, off, lp;
	logic [7:0] addr, wdata, rdata, lag, d, m;
	logic [7:0] exp_q[$];
	int         fail_count, checks, seed, i;
	rcv_top i_rcv_top (.core_clk(core_clk), .rstn(rstn), .sfr_addr(addr),
		.sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
		.sfr_sel(sel), .vbus_pin(pin), .vbus_irq_enable(en),
		.usb_reset_source_sel(src), .vbus_irq(irq), .vbus_sys_reset(srst),
		.regulator_off(off), .regulator_low_power_sel(lp));
	rcv_vbus_host i_rcv_vbus_host (.want_on(want), .lag_ns(lag), .vbus_pin(pin));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] e);
		checks++;
		if (seen !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", s, e, seen);
		end
	endtask
	task automatic close_out;
		if (fail_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Request held until the next edge; idle releases it
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
		addr = a;
		wdata = v;
		wr = w;
		rd = !w;
		if (!w) exp_q.push_back(a == 8'hc9 ? {m[7], want, m[5:4], 4'h0} : 8'h00);
		@(posedge core_clk);
		#1;
	endtask
	task automatic idle;
		wr = 1'b0;
		rd = 1'b0;
		@(posedge core_clk);
		#1;
	endtask
	always @(posedge core_clk) begin
		rd_q <= rd;
		if (rd_q) chk("rdata", rdata, exp_q.pop_front());
		chk("sel", 8'(sel), 8'(addr == 8'hc9));
	end
	initial begin
		#500000;
		fail_count++;
		close_out();
	end
	initial begin
		{rstn, wr, rd, en, src, want, addr, wdata, lag, m} = '0;
		seed = 43;
		repeat (8) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		acc(1'b0, 8'hc9, 8'h00);
		idle();
		for (i = 0; i < 32; i++) begin
			d = 8'($random(seed));
			old = want == m[5];
			{en, src, want} = d[2:0];
			lag = {5'h0, d[3:1]} * 8'h05;
			@(posedge core_clk);
			#1;
			chk("sync", 8'(irq), 8'(en && old));
			// Software keeps the reserved bits zero
			acc(1'b1, 8'hc9, d & 8'hf0);
			m = d & 8'hb0;
			acc(1'b1, 8'hc8, ~d & 8'hf0);
			idle();
			repeat (3) @(posedge core_clk);
			#1;
			acc(1'b0, 8'hc9, 8'h00);
			acc(1'b0, 8'(8'hca + d[7:6]), 8'h00);
			idle();
			chk("off", 8'(off), 8'(m[7]));
			chk("lp", 8'(lp), 8'(m[4]));
			chk("irq", 8'(irq), 8'(en && want == m[5]));
			chk("srst", 8'(srst), 8'(src && want == m[5]));
		end
		// Mid-run reset must clear a written register
		acc(1'b1, 8'hc9, 8'hb0);
		{en, src, rstn} = 3'h6;
		@(posedge core_clk);
		#1;
		chk("reset", 8'({irq, srst, off, lp}), 8'h00);
		close_out();
	end
endmodule // tb
`default_nettype wire
